// *** design/tap_master_map.vh ***
// Register indices, field positions, reset values and codes
`ifndef TAP_MASTER_MAP_VH
`define TAP_MASTER_MAP_VH
`define IDX_CMD 3'h0
`define IDX_CTRL 3'h1
`define IDX_DIV 3'h2
`define IDX_PIPE 3'h3
`define IDX_CNT 3'h4
`define IDX_FIFO 3'h5
`define IDX_DISC 3'h6
`define IDX_ADDR 3'h7
`define OP_MOVE 4'h0
`define OP_RUN 4'h1
`define OP_SCAN 4'h2
`define OP_SCAN_IN 4'h3
`define OP_SCAN_OUT 4'h4
`define OP_RECIRC 4'h5
`define OP_MDROP 4'h6
`define CMD_IR_BIT 6
`define CLK_FREE 2'h0
`define CLK_GATED 2'h1
`define CLK_DISC 2'h2
`define CTRL_LB_TDO 2
`define CTRL_LB_TMS 3
`define CTRL_TRST 4
`define CTRL_RST 8'h10
`define DIV_RST 8'h07
`define TAP_RESET 4'hF
`define TAP_IDLE 4'hC
`define TAP_SELDR 4'h7
`define TAP_CAPDR 4'h6
`define TAP_SHDR 4'h2
`define TAP_EX1DR 4'h1
`define TAP_PSDR 4'h3
`define TAP_EX2DR 4'h0
`define TAP_UPDR 4'h5
`define TAP_SELIR 4'h4
`define TAP_CAPIR 4'hE
`define TAP_SHIR 4'hA
`define TAP_EX1IR 4'h9
`define TAP_PSIR 4'hB
`define TAP_EX2IR 4'h8
`define TAP_UPIR 4'hD
`endif

// *** design/byte_fifo4.v ***
// Four-entry byte FIFO with registered read data
`timescale 1ns/10ps
`default_nettype none
module byte_fifo4 (
  input wire clk,
  input wire rst_n,
  input wire push,
  input wire [7:0] din,
  input wire pop,
  output reg [7:0] dout_q,
  output wire full,
  output wire empty
);
  reg [7:0] mem [0:3];
  reg [1:0] wr_q;
  reg [1:0] rd_q;
  reg [2:0] cnt_q;
  wire do_push = push & ~full;
  wire do_pop = pop & ~empty;
  assign full = cnt_q[2];
  assign empty = (cnt_q == 3'h0);
  always @(posedge clk) begin
    if (do_push) begin
      mem[wr_q] <= din;
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= 2'h0;
      rd_q <= 2'h0;
      cnt_q <= 3'h0;
      dout_q <= 8'h00;
    end else begin
      if (do_push) wr_q <= wr_q + 2'h1;
      if (do_pop) begin
        rd_q <= rd_q + 2'h1;
        dout_q <= mem[rd_q];
      end
      cnt_q <= cnt_q + {2'h0, do_push} - {2'h0, do_pop};
    end
  end
endmodule
`default_nettype wire

// *** design/tck_gen.v ***
// Test clock divider with free-running and gated operation
`timescale 1ns/10ps
`default_nettype none
module tck_gen (
  input wire clk,
  input wire rst_n,
  input wire [7:0] half_div,
  input wire free,
  input wire run,
  output reg tck_q,
  output reg rise_q,
  output reg fall_q
);
  reg [7:0] cnt_q;
  wire due = (cnt_q >= half_div) & ~rise_q & ~fall_q;
  wire toggle = due & (free | run);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 8'h00;
      tck_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      rise_q <= toggle & ~tck_q;
      fall_q <= toggle & tck_q;
      if (toggle) begin
        tck_q <= ~tck_q;
        cnt_q <= 8'h00;
      end else if (!due) begin
        cnt_q <= cnt_q + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

// *** design/jtag_tap_master_host_port.v ***
// Test-access-port master with byte-wide strobed host port
// Operation
// - Byte data bus, three-bit register index
// - Drop ready until access can complete
// - Commands move TAP, scan, run-test
// - 32-bit counter sets cycle count
// - Host bytes fill write FIFO, serialised out
// - Input-only and output-only scans supported
// - Recirculate mirrors TDI back onto TDO
// - Multidrop scan sends address first
// - Loopback of TDO or TMS stream
// - Free mode: clock always toggles
// - Gated mode: clock only during activity
// - Programmable divisor in both modes
// - Discrete mode: host writes drive bus
// - Align capture for pipeline up to 15
// - Enable low drives, else outputs released
// - Drive clock, mode, data, optional reset
// - Reset: ignore writes; ready, TMS, TDO, TRST high, TCK low
// - Access spans strobe fall to rise
// - Drive data only reading with strobe low
// - Index selects register directly
`timescale 1ns/10ps
`default_nettype none
`include "tap_master_map.vh"
module jtag_tap_master_host_port (
  input wire clk,
  input wire rst_n,
  input wire host_access_strobe,
  input wire host_rw,
  input wire [2:0] host_reg_index,
  input wire [7:0] host_byte_bus_in,
  output reg [7:0] host_byte_bus_out,
  output reg host_byte_bus_oe,
  output reg host_ready,
  input wire test_output_enable_n,
  input wire tdi_in,
  output reg tck_out,
  output reg tms_out,
  output reg tdo_out,
  output reg trst_n_out,
  output reg tap_oe
);
  localparam ST_IDLE = 3'd0;
  localparam ST_MOVE = 3'd1;
  localparam ST_SHIFT = 3'd2;
  localparam ST_RUN = 3'd3;
  localparam ST_DRAIN = 3'd4;
  localparam ST_FLUSH = 3'd5;

  function [3:0] tap_next;
    input [3:0] s;
    input t;
    begin
      case (s)
        `TAP_RESET: tap_next = t ? `TAP_RESET : `TAP_IDLE;
        `TAP_IDLE: tap_next = t ? `TAP_SELDR : `TAP_IDLE;
        `TAP_SELDR: tap_next = t ? `TAP_SELIR : `TAP_CAPDR;
        `TAP_CAPDR: tap_next = t ? `TAP_EX1DR : `TAP_SHDR;
        `TAP_SHDR: tap_next = t ? `TAP_EX1DR : `TAP_SHDR;
        `TAP_EX1DR: tap_next = t ? `TAP_UPDR : `TAP_PSDR;
        `TAP_PSDR: tap_next = t ? `TAP_EX2DR : `TAP_PSDR;
        `TAP_EX2DR: tap_next = t ? `TAP_UPDR : `TAP_SHDR;
        `TAP_UPDR: tap_next = t ? `TAP_SELDR : `TAP_IDLE;
        `TAP_SELIR: tap_next = t ? `TAP_RESET : `TAP_CAPIR;
        `TAP_CAPIR: tap_next = t ? `TAP_EX1IR : `TAP_SHIR;
        `TAP_SHIR: tap_next = t ? `TAP_EX1IR : `TAP_SHIR;
        `TAP_EX1IR: tap_next = t ? `TAP_UPIR : `TAP_PSIR;
        `TAP_PSIR: tap_next = t ? `TAP_EX2IR : `TAP_PSIR;
        `TAP_EX2IR: tap_next = t ? `TAP_UPIR : `TAP_SHIR;
        default: tap_next = t ? `TAP_SELDR : `TAP_IDLE;
      endcase
    end
  endfunction

  // TMS value that takes state s one step toward goal g
  function tap_tms;
    input [3:0] s;
    input [3:0] g;
    reg ir;
    begin
      ir = (g == `TAP_SHIR) | (g == `TAP_PSIR);
      case (s)
        `TAP_RESET: tap_tms = (g == `TAP_RESET);
        `TAP_IDLE: tap_tms = (g != `TAP_IDLE);
        `TAP_SELDR: tap_tms = ir;
        `TAP_SELIR: tap_tms = ~ir;
        `TAP_CAPDR, `TAP_SHDR, `TAP_EX2DR: tap_tms = (g != `TAP_SHDR);
        `TAP_CAPIR, `TAP_SHIR, `TAP_EX2IR: tap_tms = (g != `TAP_SHIR);
        `TAP_EX1DR, `TAP_PSDR: tap_tms = (g != `TAP_PSDR);
        `TAP_EX1IR, `TAP_PSIR: tap_tms = (g != `TAP_PSIR);
        default: tap_tms = (g != `TAP_IDLE);
      endcase
      if (g == `TAP_RESET) tap_tms = 1'b1;
    end
  endfunction

  function [3:0] end_state;
    input [1:0] e;
    begin
      case (e)
        2'h0: end_state = `TAP_RESET;
        2'h1: end_state = `TAP_IDLE;
        2'h2: end_state = `TAP_PSDR;
        default: end_state = `TAP_PSIR;
      endcase
    end
  endfunction

  // Two-stage synchronisers for pins from the host and target side
  reg [1:0] host_access_strobe_s, rw_s, toe_s, tdi_s;
  reg [2:0] idx_s1, idx_s2;
  reg [7:0] dat_s1, dat_s2;
  reg host_access_strobe_d_q;
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_access_strobe_s <= 2'b11;
      host_access_strobe_d_q <= 1'b1;
      rw_s <= 2'b00;
      toe_s <= 2'b11;
      tdi_s <= 2'b11;
      idx_s1 <= 3'h0;
      idx_s2 <= 3'h0;
      dat_s1 <= 8'h00;
      dat_s2 <= 8'h00;
    end else begin
      host_access_strobe_s <= {host_access_strobe_s[0], host_access_strobe};
      host_access_strobe_d_q <= host_access_strobe_s[1];
      rw_s <= {rw_s[0], host_rw};
      toe_s <= {toe_s[0], test_output_enable_n};
      tdi_s <= {tdi_s[0], tdi_in};
      idx_s1 <= host_reg_index;
      idx_s2 <= idx_s1;
      dat_s1 <= host_byte_bus_in;
      dat_s2 <= dat_s1;
    end
  end

  reg [2:0] st_q;
  reg [3:0] op_q, goal_q, tap_q, tx_left_q, addr_ph_q, pipe_q;
  reg [1:0] end_q;
  reg [7:0] ctrl_q, div_q, addr_q, tx_sh_q, rx_sh_q;
  reg [31:0] cnt_q;
  reg [14:0] hist_q;
  reg [2:0] rx_n_q;
  reg tms_nx_q, ph2_q, tx_ld_q, acc_q, rd_ld_q, disc_tck_q;
  wire [7:0] wf_dout, rf_dout;
  wire wf_full, wf_empty, rf_full, rf_empty, gen_tck, rise, fall;

  wire disc = (ctrl_q[1:0] == `CLK_DISC);
  wire host_access_strobe_fall = host_access_strobe_d_q & ~host_access_strobe_s[1];
  wire host_access_strobe_rise = ~host_access_strobe_d_q & host_access_strobe_s[1];
  wire rd = rw_s[1];
  wire [2:0] idx = idx_s2;
  wire tx_use = (op_q == `OP_SCAN) | (op_q == `OP_SCAN_OUT) |
                (op_q == `OP_MDROP) | (addr_ph_q != 4'h0);
  wire cap_op = (op_q == `OP_SCAN) | (op_q == `OP_SCAN_IN) |
                (op_q == `OP_RECIRC) | (op_q == `OP_MDROP);
  wire loop_on = ctrl_q[`CTRL_LB_TDO] | ctrl_q[`CTRL_LB_TMS];
  wire cur_cap = (st_q == ST_SHIFT) & cap_op & (addr_ph_q == 4'h0);
  wire pipe_cap = (pipe_q == 4'h0) ? cur_cap : hist_q[pipe_q - 4'h1];
  wire cap_now = loop_on ? cur_cap : pipe_cap;
  wire cap_bit = ctrl_q[`CTRL_LB_TDO] ? tdo_out :
                 ctrl_q[`CTRL_LB_TMS] ? tms_out : tdi_s[1];
  wire tx_need = (st_q == ST_SHIFT) & tx_use & (tx_left_q == 4'h0);
  wire stall = tx_need | (rf_full & cap_op & (st_q != ST_IDLE));
  wire busy = (st_q != ST_IDLE);
  wire gen_run = (busy & ~stall) | (gen_tck & ~busy);
  wire step = rise & busy & ~disc;
  wire [3:0] tap_adv = tap_next(tap_q, tms_out);
  wire [3:0] cmd_goal = (dat_s2[3:0] == `OP_MOVE) ?
                        end_state(dat_s2[5:4]) :
                        (dat_s2[3:0] == `OP_RUN) ? `TAP_IDLE :
                        dat_s2[`CMD_IR_BIT] ? `TAP_SHIR : `TAP_SHDR;
  wire goal_shift = (goal_q == `TAP_SHDR) | (goal_q == `TAP_SHIR);
  wire last_nx = (addr_ph_q > 4'h1) ? 1'b0 :
                 (addr_ph_q == 4'h1) ? (cnt_q == 32'h1) :
                 (cnt_q == 32'h2);
  // Access may complete now, else ready is dropped
  wire can_go = rd ? ((idx != `IDX_FIFO) | ~rf_empty) :
                (idx == `IDX_FIFO) ? ~wf_full :
                (idx == `IDX_CMD) ? ~busy : 1'b1;
  wire acc_go = (host_access_strobe_fall | acc_q) & can_go & ~host_access_strobe_s[1];
  wire wr_go = acc_go & ~rd;
  wire rf_push_cap = step & cap_now & (rx_n_q == 3'h7);
  wire rf_flush = (st_q == ST_FLUSH) & (rx_n_q != 3'h0) & ~rf_full;
  wire [7:0] rx_full_byte = {cap_bit, rx_sh_q[7:1]};
  wire [7:0] rx_part = rx_sh_q >> (4'h8 - {1'b0, rx_n_q});
  wire wf_pop = tx_need & ~wf_empty & ~tx_ld_q;

  byte_fifo4 u_wfifo (
    .clk(clk),
    .rst_n(rst_n),
    .push(wr_go & (idx == `IDX_FIFO)),
    .din(dat_s2),
    .pop(wf_pop),
    .dout_q(wf_dout),
    .full(wf_full),
    .empty(wf_empty)
  );
  byte_fifo4 u_rfifo (
    .clk(clk),
    .rst_n(rst_n),
    .push(rf_push_cap | rf_flush),
    .din(rf_flush ? rx_part : rx_full_byte),
    .pop(acc_go & rd & (idx == `IDX_FIFO)),
    .dout_q(rf_dout),
    .full(rf_full),
    .empty(rf_empty)
  );
  tck_gen u_tck (
    .clk(clk),
    .rst_n(rst_n),
    .half_div(div_q),
    .free(ctrl_q[1:0] == `CLK_FREE),
    .run(gen_run),
    .tck_q(gen_tck),
    .rise_q(rise),
    .fall_q(fall)
  );

  // Host port: handshake, read data and pin outputs
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_ready <= 1'b1;
      host_byte_bus_oe <= 1'b0;
      host_byte_bus_out <= 8'h00;
      acc_q <= 1'b0;
      rd_ld_q <= 1'b0;
      tap_oe <= 1'b0;
      trst_n_out <= 1'b1;
      tck_out <= 1'b0;
    end else begin
      host_byte_bus_oe <= rw_s[1] & ~host_access_strobe_s[1];
      acc_q <= (host_access_strobe_fall | acc_q) & ~can_go & ~host_access_strobe_s[1];
      if (host_access_strobe_rise | acc_go) host_ready <= 1'b1;
      else if (host_access_strobe_fall & ~can_go) host_ready <= 1'b0;
      rd_ld_q <= acc_go & rd & (idx == `IDX_FIFO);
      if (rd_ld_q) host_byte_bus_out <= rf_dout;
      else if (acc_go & rd) begin
        if (idx == `IDX_CMD)
          host_byte_bus_out <= {busy, wf_full, ~rf_empty, 1'b0, tap_q};
        else if (idx == `IDX_CTRL) host_byte_bus_out <= ctrl_q;
        else if (idx == `IDX_DIV) host_byte_bus_out <= div_q;
        else if (idx == `IDX_PIPE) host_byte_bus_out <= {4'h0, pipe_q};
        else if (idx == `IDX_CNT) host_byte_bus_out <= cnt_q[7:0];
        else if (idx == `IDX_DISC)
          host_byte_bus_out <= {5'h00, tdi_s[1], tms_out, tdo_out};
        else if (idx == `IDX_ADDR) host_byte_bus_out <= addr_q;
      end
      tap_oe <= ~toe_s[1];
      trst_n_out <= ctrl_q[`CTRL_TRST];
      tck_out <= disc ? disc_tck_q : gen_tck;
    end
  end

  // Scan engine and configuration registers
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      op_q <= `OP_MOVE;
      goal_q <= `TAP_RESET;
      end_q <= 2'h0;
      tap_q <= `TAP_RESET;
      ctrl_q <= `CTRL_RST;
      div_q <= `DIV_RST;
      pipe_q <= 4'h0;
      addr_q <= 8'h00;
      cnt_q <= 32'h0;
      tms_nx_q <= 1'b1;
      tms_out <= 1'b1;
      tdo_out <= 1'b1;
      disc_tck_q <= 1'b0;
      ph2_q <= 1'b0;
      tx_sh_q <= 8'h00;
      tx_left_q <= 4'h0;
      tx_ld_q <= 1'b0;
      addr_ph_q <= 4'h0;
      hist_q <= 15'h0;
      rx_sh_q <= 8'h00;
      rx_n_q <= 3'h0;
    end else begin
      tx_ld_q <= wf_pop;
      if (tx_ld_q) begin
        tx_sh_q <= wf_dout;
        tx_left_q <= 4'h8;
      end
      if (wr_go) begin
        if (idx == `IDX_CTRL) ctrl_q <= dat_s2;
        else if (idx == `IDX_DIV) div_q <= dat_s2;
        else if (idx == `IDX_PIPE) pipe_q <= dat_s2[3:0];
        else if (idx == `IDX_CNT) cnt_q <= {cnt_q[23:0], dat_s2};
        else if (idx == `IDX_ADDR) addr_q <= dat_s2;
        else if (idx == `IDX_DISC && disc) begin
          tms_out <= dat_s2[0];
          tdo_out <= dat_s2[1];
          disc_tck_q <= dat_s2[2];
          if (dat_s2[2] & ~disc_tck_q) tap_q <= tap_next(tap_q, dat_s2[0]);
        end else if (idx == `IDX_CMD && !disc) begin
          op_q <= dat_s2[3:0];
          end_q <= dat_s2[5:4];
          goal_q <= cmd_goal;
          ph2_q <= 1'b0;
          st_q <= ST_MOVE;
          tms_nx_q <= tap_tms(tap_q, cmd_goal);
          if (dat_s2[3:0] == `OP_MDROP) begin
            tx_sh_q <= addr_q;
            tx_left_q <= 4'h8;
            addr_ph_q <= 4'h8;
          end else begin
            tx_left_q <= 4'h0;
          end
        end
      end
      if (fall & busy & ~disc) begin
        tms_out <= tms_nx_q;
        if (st_q != ST_SHIFT) tdo_out <= 1'b1;
        else if (op_q == `OP_RECIRC) tdo_out <= tdi_s[1];
        else if (tx_use) tdo_out <= tx_sh_q[0];
        else tdo_out <= 1'b1;
      end
      if (step) begin
        tap_q <= tap_adv;
        hist_q <= {hist_q[13:0], cur_cap};
        if (cap_now) begin
          rx_sh_q <= rx_full_byte;
          rx_n_q <= rx_n_q + 3'h1;
        end
        case (st_q)
          ST_MOVE: begin
            if (tap_adv != goal_q) tms_nx_q <= tap_tms(tap_adv, goal_q);
            else if (!ph2_q && goal_shift) begin
              st_q <= ST_SHIFT;
              tms_nx_q <= (addr_ph_q == 4'h0) & (cnt_q == 32'h1);
            end else if (!ph2_q && op_q == `OP_RUN) begin
              st_q <= ST_RUN;
              tms_nx_q <= 1'b0;
            end else begin
              st_q <= ST_DRAIN;
              tms_nx_q <= (tap_adv == `TAP_RESET);
            end
          end
          ST_SHIFT: begin
            if (tx_use) begin
              tx_sh_q <= {1'b0, tx_sh_q[7:1]};
              tx_left_q <= tx_left_q - 4'h1;
            end
            if (addr_ph_q != 4'h0) addr_ph_q <= addr_ph_q - 4'h1;
            else cnt_q <= cnt_q - 32'h1;
            if (tms_out) begin
              ph2_q <= 1'b1;
              goal_q <= end_state(end_q);
              st_q <= ST_MOVE;
              tms_nx_q <= tap_tms(tap_adv, end_state(end_q));
            end else begin
              tms_nx_q <= last_nx;
            end
          end
          ST_RUN: begin
            cnt_q <= cnt_q - 32'h1;
            if (cnt_q <= 32'h1) begin
              ph2_q <= 1'b1;
              goal_q <= end_state(end_q);
              st_q <= ST_MOVE;
              tms_nx_q <= tap_tms(`TAP_IDLE, end_state(end_q));
            end
          end
          ST_DRAIN: begin
            if (hist_q[13:0] == 14'h0) st_q <= ST_FLUSH;
          end
          default: st_q <= st_q;
        endcase
      end
      if (st_q == ST_FLUSH && !rf_full) begin
        rx_n_q <= 3'h0;
        st_q <= ST_IDLE;
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/tap_target_model.sv ***
// Single target TAP controller with an eight-bit data register
`timescale 1ns/10ps
`default_nettype none
`include "tap_master_map.vh"
module tap_target_model #(
  parameter logic [7:0] CAPTURE = 8'h3C
) (
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output var logic tdo
);
  logic [3:0] state;
  logic [7:0] dr;
  function automatic logic [3:0] next_st(input logic [3:0] s, input logic t);
    case (s)
      `TAP_RESET: next_st = t ? `TAP_RESET : `TAP_IDLE;
      `TAP_IDLE: next_st = t ? `TAP_SELDR : `TAP_IDLE;
      `TAP_SELDR: next_st = t ? `TAP_SELIR : `TAP_CAPDR;
      `TAP_CAPDR, `TAP_SHDR: next_st = t ? `TAP_EX1DR : `TAP_SHDR;
      `TAP_EX1DR: next_st = t ? `TAP_UPDR : `TAP_PSDR;
      `TAP_PSDR: next_st = t ? `TAP_EX2DR : `TAP_PSDR;
      `TAP_EX2DR: next_st = t ? `TAP_UPDR : `TAP_SHDR;
      `TAP_SELIR: next_st = t ? `TAP_RESET : `TAP_CAPIR;
      `TAP_CAPIR, `TAP_SHIR: next_st = t ? `TAP_EX1IR : `TAP_SHIR;
      `TAP_EX1IR: next_st = t ? `TAP_UPIR : `TAP_PSIR;
      `TAP_PSIR: next_st = t ? `TAP_EX2IR : `TAP_PSIR;
      `TAP_EX2IR: next_st = t ? `TAP_UPIR : `TAP_SHIR;
      default: next_st = t ? `TAP_SELDR : `TAP_IDLE;
    endcase
  endfunction
  initial tdo = 1'b1;
  always @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      state <= `TAP_RESET;
    end else begin
      if (state == `TAP_CAPDR) dr <= CAPTURE;
      else if (state == `TAP_SHDR) dr <= {tdi, dr[7:1]};
      state <= next_st(state, tms);
    end
  end
  // Released line shows the inverse of its last value
  always @(negedge tck) begin
    tdo <= (state == `TAP_SHDR) ? dr[0] : ~tdo;
  end
endmodule
`default_nettype wire

// *** verification/tap_master_chk.sv ***
// Pin-level checks on the test-port master
`timescale 1ns/10ps
`default_nettype none
module tap_master_chk (
  input wire clk,
  input wire rst_n,
  input wire host_access_strobe,
  input wire host_rw,
  input wire [2:0] host_reg_index,
  input wire [7:0] host_byte_bus_in,
  input wire [7:0] host_byte_bus_out,
  input wire host_byte_bus_oe,
  input wire host_ready,
  input wire test_output_enable_n,
  input wire tdi_in,
  input wire tck_out,
  input wire tms_out,
  input wire tdo_out,
  input wire trst_n_out,
  input wire tap_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  reset_values_a: assert property (
    $rose(rst_n) |-> host_ready && tms_out && tdo_out && trst_n_out)
    else $error("outputs not at reset level");
  bus_release_a: assert property (
    ((host_access_strobe || !host_rw)[*4]) |-> !host_byte_bus_oe)
    else $error("data bus driven outside a read");
  bus_drive_a: assert property (
    $rose(host_byte_bus_oe) |->
      $past(host_rw, 2) && !$past(host_access_strobe, 2))
    else $error("data bus driven without read strobe");
  ready_release_a: assert property (
    (host_access_strobe[*6]) |-> host_ready)
    else $error("ready low with strobe high");
  ready_wait_a: assert property (
    $fell(host_ready) |-> !$past(host_access_strobe, 2))
    else $error("ready dropped outside an access");
  tap_off_a: assert property (
    (test_output_enable_n[*4]) |-> !tap_oe)
    else $error("test bus driven while disabled");
  tap_on_a: assert property (
    (!test_output_enable_n[*4]) |-> tap_oe)
    else $error("test bus not driven while enabled");
  tck_half_a: assert property (
    $changed(tck_out) |=> $stable(tck_out))
    else $error("test clock half period under two cycles");
  cover property ($fell(host_ready));
  cover property ($rose(host_byte_bus_oe));
  cover property ($rose(tck_out));
  cover property ($fell(tap_oe));
endmodule
bind jtag_tap_master_host_port tap_master_chk u_chk (.clk, .rst_n,
  .host_access_strobe, .host_rw, .host_reg_index, .host_byte_bus_in,
  .host_byte_bus_out, .host_byte_bus_oe, .host_ready,
  .test_output_enable_n, .tdi_in, .tck_out, .tms_out, .tdo_out,
  .trst_n_out, .tap_oe);
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for the test-port master
`timescale 1ns/10ps
`default_nettype none
`include "tap_master_map.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin bad_count++; \
  $display("[FAIL] %0t: got %h exp %h", $time, g, e); end end
module testbench;
  logic clk, rst_n, strobe, rw, toe_n, w;
  logic [2:0] idx;
  logic [7:0] wdata, q, bus_out;
  logic bus_oe, ready, tck, tms, tdo, trst_n, tap_oe, tdi;
  int bad_count, cmp_count, cyc, h, k;
  logic [3:0] ops [2] = '{`OP_SCAN, `OP_SCAN_OUT};
  logic [7:0] pat [2] = '{8'hA5, 8'h5A};
  jtag_tap_master_host_port u_dut (.clk(clk), .rst_n(rst_n),
    .host_access_strobe(strobe), .host_rw(rw), .host_reg_index(idx),
    .host_byte_bus_in(bus_oe ? bus_out : wdata),
    .host_byte_bus_out(bus_out), .host_byte_bus_oe(bus_oe),
    .host_ready(ready), .test_output_enable_n(toe_n), .tdi_in(tdi),
    .tck_out(tck), .tms_out(tms), .tdo_out(tdo), .trst_n_out(trst_n),
    .tap_oe(tap_oe));
  tap_target_model u_tgt (.tck(tck), .tms(tms), .tdi(tdo),
    .trst_n(trst_n), .tdo(tdi));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic access(input logic r, input logic [2:0] i,
      input logic [7:0] d, output logic [7:0] rq, output logic wt);
    int n;
    n = 0;
    wt = 1'b0;
    @(negedge clk);
    rw = r; idx = i; wdata = d;
    @(negedge clk);
    strobe = 1'b0;
    while ((n < 7 || ready !== 1'b1) && n < 5000) begin
      @(negedge clk);
      n++;
      if (ready !== 1'b1) wt = 1'b1;
    end
    repeat (3) @(negedge clk);
    rq = bus_out;
    strobe = 1'b1;
    repeat (5) @(negedge clk);
  endtask
  task automatic wr(input logic [2:0] i, input logic [7:0] d);
    logic [7:0] rq;
    logic wt;
    access(1'b0, i, d, rq, wt);
  endtask
  task automatic rd(input logic [2:0] i, output logic [7:0] rq);
    logic wt;
    access(1'b1, i, 8'h00, rq, wt);
  endtask
  task automatic wait_idle();
    for (int n = 0; n < 300; n++) begin
      rd(`IDX_CMD, q);
      if (q[7] === 1'b0) break;
    end
  endtask
  task automatic load_cnt(input logic [7:0] lo);
    wr(`IDX_CNT, 8'h00);
    wr(`IDX_CNT, 8'h00);
    wr(`IDX_CNT, 8'h00);
    wr(`IDX_CNT, lo);
  endtask
  task automatic half(output int hp);
    logic t;
    @(negedge clk);
    t = tck;
    for (int n = 0; n < 100 && tck === t; n++) @(negedge clk);
    t = tck;
    hp = 0;
    while (tck === t && hp < 100) begin
      @(negedge clk);
      hp++;
    end
  endtask
  task end_of_test;
    $display("Mismatches %0d, comparisons %0d", bad_count, cmp_count);
    if (bad_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    rst_n = 1'b0; strobe = 1'b1; rw = 1'b0; idx = 3'h0;
    wdata = 8'h00; toe_n = 1'b0;
    repeat (10) @(negedge clk);
    rst_n = 1'b1;
    rd(`IDX_CTRL, q); `CHK(q, `CTRL_RST);
    rd(`IDX_DIV, q); `CHK(q, `DIV_RST);
    for (k = 1; k < 4; k += 2) begin
      wr(`IDX_DIV, k[7:0]);
      half(h); `CHK(h, k + 1);
    end
    wr(`IDX_DIV, 8'h02);
    wr(`IDX_CTRL, 8'h11);
    half(h); `CHK(h, 100);
    wr(`IDX_CMD, 8'h10);
    wait_idle(); `CHK(q[3:0], `TAP_IDLE);
    `CHK(u_tgt.state, `TAP_IDLE);
    for (k = 0; k < 2; k++) begin
      load_cnt(8'h08);
      wr(`IDX_FIFO, pat[k]);
      wr(`IDX_CMD, {4'h1, ops[k]});
      wait_idle(); `CHK(u_tgt.dr, pat[k]);
      `CHK(q[5], k == 0);
      if (k == 0) begin
        rd(`IDX_FIFO, q); `CHK(q, 8'h3C);
      end
    end
    wr(`IDX_DIV, 8'h10);
    load_cnt(8'h08);
    wr(`IDX_CMD, {4'h1, `OP_SCAN_IN});
    access(1'b1, `IDX_FIFO, 8'h00, q, w); `CHK(w, 1'b1);
    `CHK(q, 8'h3C);
    wait_idle(); `CHK(u_tgt.dr, 8'hFF);
    wr(`IDX_DIV, 8'h02);
    for (k = 0; k < 2; k++) begin
      wr(`IDX_CTRL, k ? 8'h19 : 8'h15);
      load_cnt(8'h08);
      if (k == 0) wr(`IDX_FIFO, 8'h96);
      wr(`IDX_CMD, {4'h1, k ? `OP_SCAN_IN : `OP_SCAN});
      wait_idle();
      rd(`IDX_FIFO, q); `CHK(q, k ? 8'h80 : 8'h96);
    end
    wr(`IDX_CTRL, 8'h11);
    wr(`IDX_ADDR, 8'hC3);
    load_cnt(8'h04);
    wr(`IDX_FIFO, 8'h96);
    wr(`IDX_CMD, {4'h1, `OP_MDROP});
    wait_idle(); `CHK(u_tgt.dr, 8'h6C);
    rd(`IDX_FIFO, q); `CHK(q, 8'h03);
    load_cnt(8'h05);
    wr(`IDX_CMD, {4'h1, `OP_RUN});
    wait_idle(); `CHK(u_tgt.state, `TAP_IDLE);
    rd(`IDX_CNT, q); `CHK(q, 8'h00);
    wr(`IDX_DIV, 8'h01);
    load_cnt(8'h08);
    wr(`IDX_CMD, {4'h1, `OP_RECIRC});
    wait_idle(); `CHK(u_tgt.dr[7:1], 7'h3C);
    toe_n = 1'b1;
    repeat (5) @(negedge clk); `CHK(tap_oe, 1'b0);
    toe_n = 1'b0;
    repeat (5) @(negedge clk); `CHK(tap_oe, 1'b1);
    wr(`IDX_CTRL, 8'h02); `CHK(trst_n, 1'b0);
    wr(`IDX_DISC, 8'h06); `CHK({tck, tdo, tms}, 3'b110);
    wr(`IDX_DISC, 8'h01); `CHK({tck, tdo, tms}, 3'b001);
    rd(`IDX_DISC, q); `CHK(q[1:0], 2'b10);
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    `CHK({ready, tms, tdo, trst_n}, 4'hF);
    wr(`IDX_CTRL, 8'h03);
    rst_n = 1'b1;
    rd(`IDX_CTRL, q); `CHK(q, `CTRL_RST);
    end_of_test();
  end
endmodule
`default_nettype wire
